// >>> rlh_host_ctrl.sv
// Host controller: device clock, init, commands, write and read paths
`timescale 1ns/1ps
`default_nettype none
module rlh_host_ctrl
  import rlh_pkg::*;
#(
  parameter int DW     = 36,
  parameter int AW     = 21,
  parameter int IDLE_N = IDLE_SLOTS
) (
  input  wire logic            clk,
  input  wire logic            sys_rst,
  input  wire logic            clk_en,
  input  wire logic            pwr_ok,
  input  wire logic [AW-1:0]   mode_cfg,
  input  wire logic            usr_req,
  input  wire logic            usr_we,
  input  wire logic [2:0]      usr_bank,
  input  wire logic [AW-1:0]   usr_addr,
  input  wire logic [2*DW-1:0] usr_wdata,
  input  wire logic [1:0]      usr_wmask,
  output logic                 usr_ready,
  output logic                 init_done,
  output logic [DW-1:0]        rd_data,
  output logic                 rd_valid,
  output logic                 ck_p,
  output logic                 ck_n,
  output logic                 cs_n,
  output logic                 we_n,
  output logic                 ref_n,
  output logic [AW-1:0]        addr_o,
  output logic [2:0]           bank_o,
  output logic [1:0]           in_data_strobe_p,
  output logic [1:0]           in_data_strobe_n,
  output logic                 wmask_o,
  output logic [DW-1:0]        dq_o,
  output logic                 dq_oe,
  input  wire logic [DW-1:0]   dq_i,
  input  wire logic [1:0]      out_data_strobe_i,
  input  wire logic            read_valid_i
);
  localparam int HB  = DW / 2;
  localparam int TW  = $clog2(TRC_SLOTS + 1);
  localparam int WLW = $clog2(WL_SLOTS + 1);
  localparam int RW  = DW + 3;

  rlh_init_if ifc ();

  logic [1:0]      ph_reg;
  logic            pwr_s1_reg;
  logic            pwr_s2_reg;
  logic [RW-1:0]   rs1_reg;
  logic [RW-1:0]   rs2_reg;
  logic [1:0]      ods_prev_reg;
  logic [1:0]      qedge_reg;
  logic            req_pend_reg;
  logic            req_we_reg;
  logic [2:0]      req_bank_reg;
  logic [AW-1:0]   req_addr_reg;
  logic [2*DW-1:0] req_data_reg;
  logic [1:0]      req_mask_reg;
  logic            wr_pend_reg;
  logic [WLW-1:0]  wl_cnt_reg;
  logic            accept;
  logic            issue;
  logic            strobe_lvl;
  rlh_cmd_t        cur_cmd;
  logic [2:0]      cur_bank;
  logic [AW-1:0]   cur_addr;
  logic [TW-1:0]   trc_cnt [NUM_BANKS];

  rlh_init_seq #(
    .IDLE_N (IDLE_N)
  ) u_seq (
    .clk     (clk),
    .sys_rst (sys_rst),
    .clk_en  (clk_en),
    .ifc     (ifc.seq)
  );

  // Synchronisers for supply status and read pins
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pwr_s1_reg <= 1'h0;
      pwr_s2_reg <= 1'h0;
      rs1_reg    <= '0;
      rs2_reg    <= '0;
      ods_prev_reg <= 2'h0;
      qedge_reg  <= 2'h0;
    end else if (clk_en) begin
      pwr_s1_reg <= pwr_ok;
      pwr_s2_reg <= pwr_s1_reg;
      rs1_reg      <= {read_valid_i, out_data_strobe_i, dq_i};
      rs2_reg      <= rs1_reg;
      ods_prev_reg <= rs2_reg[DW +: 2];
      qedge_reg    <= rs2_reg[DW +: 2] ^ ods_prev_reg; // R04
    end
  end

  assign ifc.pwr_ok = pwr_s2_reg;
  assign ifc.slot   = ifc.run && clk_en && (ph_reg == PH_FALL);
  assign strobe_lvl = ifc.run && (ph_reg[0] ^ ph_reg[1]);

  // Device clock and quarter-shifted data strobes
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ph_reg <= 2'h0;
      ck_p   <= 1'h0;
      ck_n   <= 1'h1;
      in_data_strobe_p <= 2'h0;
      in_data_strobe_n <= 2'h3;
    end else if (clk_en) begin
      if (ifc.run) begin
        ph_reg <= ph_reg + 2'h1; // R09
      end
      ck_p <= ifc.run && !ph_reg[1];
      ck_n <= !(ifc.run && !ph_reg[1]);
      in_data_strobe_p <= {2{strobe_lvl}}; // R02 R19
      in_data_strobe_n <= {2{!strobe_lvl}};
    end
  end

  assign accept = usr_req && usr_ready;
  assign issue  = ifc.slot && ifc.done && req_pend_reg
                  && (trc_cnt[req_bank_reg] == '0); // R17

  // Command source: sequencer during init, user afterwards
  always_comb begin
    cur_cmd  = ifc.cmd;
    cur_bank = ifc.bank;
    cur_addr = ifc.mode_valid ? mode_cfg : '0; // R15
    if (ifc.done) begin
      cur_cmd  = issue ? (req_we_reg ? CMD_WR : CMD_RD) : CMD_NOP;
      cur_bank = req_bank_reg;
      cur_addr = req_addr_reg;
    end
  end

  // Command pins change at the falling edge of the device clock
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      {cs_n, we_n, ref_n} <= PIN_NOP; // R10 R18
      addr_o              <= '0;
      bank_o              <= 3'h0;
    end else if (ifc.slot) begin
      {cs_n, we_n, ref_n} <= rlh_pins(cur_cmd); // R03
      addr_o              <= cur_addr;
      bank_o              <= cur_bank;
    end
  end

  // User request holding register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      req_pend_reg <= 1'h0;
      req_we_reg   <= 1'h0;
      req_bank_reg <= 3'h0;
      req_addr_reg <= '0;
      req_data_reg <= '0;
      req_mask_reg <= 2'h0;
      usr_ready    <= 1'h0;
      init_done    <= 1'h0;
    end else if (clk_en) begin
      if (accept) begin
        req_pend_reg <= 1'h1;
        req_we_reg   <= usr_we;
        req_bank_reg <= usr_bank;
        req_addr_reg <= usr_addr;
        req_data_reg <= usr_wdata;
        req_mask_reg <= usr_wmask;
      end else if (issue) begin
        req_pend_reg <= 1'h0;
      end
      usr_ready <= ifc.done && !accept && !req_pend_reg && !wr_pend_reg;
      init_done <= ifc.done;
    end
  end

  // Write burst: two beats against the data strobes
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_pend_reg <= 1'h0;
      wl_cnt_reg  <= '0;
      dq_o        <= '0;
      dq_oe       <= 1'h0;
      wmask_o     <= 1'h0;
    end else if (clk_en) begin
      if (issue && req_we_reg) begin
        wr_pend_reg <= 1'h1;
        wl_cnt_reg  <= WLW'(WL_SLOTS);
      end else if (wr_pend_reg && ph_reg == PH_RISE) begin
        if (wl_cnt_reg != '0) begin
          wl_cnt_reg <= wl_cnt_reg - 1'b1;
        end else begin
          dq_o    <= req_data_reg[DW-1:0]; // R19
          wmask_o <= req_mask_reg[0]; // R01 R02
          dq_oe   <= 1'h1;
        end
      end else if (wr_pend_reg && dq_oe && ph_reg == PH_FALL) begin
        dq_o        <= req_data_reg[2*DW-1:DW]; // R19
        wmask_o     <= req_mask_reg[1]; // R02
        wr_pend_reg <= 1'h0;
      end else if (ph_reg == PH_RISE) begin
        dq_oe <= 1'h0;
      end
    end
  end

  // Per-bank row cycle spacing
  generate
    for (genvar b = 0; b < NUM_BANKS; b++) begin : g_trc
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          trc_cnt[b] <= '0;
        end else if (ifc.slot) begin
          if (cur_cmd inside {CMD_REF, CMD_RD, CMD_WR}
              && cur_bank == 3'(b)) begin
            trc_cnt[b] <= TW'(TRC_SLOTS - 1); // R17
          end else if (trc_cnt[b] != '0) begin
            trc_cnt[b] <= trc_cnt[b] - 1'b1;
          end
        end
      end
    end
  endgenerate

  // Read capture on output strobe edges while read valid is high
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_data  <= '0;
      rd_valid <= 1'h0;
    end else if (clk_en) begin
      for (int i = 0; i < DW; i++) begin
        if (qedge_reg[(DW > 9 && i >= HB) ? 1 : 0] && rs2_reg[DW + 2]) begin
          rd_data[i] <= rs2_reg[i]; // R05 R06 R07
        end
      end
      rd_valid <= qedge_reg[0] && rs2_reg[DW + 2]; // R08
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst || !clk_en);

  property p_trc_gap;
    (ifc.slot && cur_cmd inside {CMD_REF, CMD_RD, CMD_WR})
      |-> trc_cnt[cur_bank] == '0;
  endproperty
  a_trc_gap: assert property (p_trc_gap) // R17
    else $error("bank command inside row cycle time");

  property p_cmd_at_fall;
    $changed({cs_n, we_n, ref_n, addr_o}) |-> $fell(ck_p);
  endproperty
  a_cmd_at_fall: assert property (p_cmd_at_fall) // R03
    else $error("command pins changed away from clock fall");

  property p_wr_beats;
    $rose(dq_oe) |-> ck_p ##1 $rose(in_data_strobe_p[1])
                     ##2 $fell(in_data_strobe_p[1]) ##1 !dq_oe;
  endproperty
  a_wr_beats: assert property (p_wr_beats) // R19
    else $error("write beats not framed by strobe edges");

  property p_mask_beats;
    $rose(dq_oe) |-> wmask_o == req_mask_reg[0]
                     ##2 wmask_o == req_mask_reg[1];
  endproperty
  a_mask_beats: assert property (p_mask_beats) // R02
    else $error("write mask beat mismatch");

  property p_dummy_low;
    (ifc.slot && ifc.cmd == CMD_MRS && !ifc.mode_valid) |=> addr_o == '0;
  endproperty
  a_dummy_low: assert property (p_dummy_low) // R15
    else $error("dummy mode set with address not low");

  property p_rd_valid;
    rd_valid |-> $past(qedge_reg[0]) && $past(rs2_reg[DW + 2]);
  endproperty
  a_rd_valid: assert property (p_rd_valid) // R08
    else $error("read data taken without valid strobe edge");

  c_init:  cover property ($rose(init_done));
  c_write: cover property ($rose(dq_oe));
  c_read:  cover property (rd_valid);
endmodule
`default_nettype wire

// >>> rlh_pkg.sv
// Package: timing, command codes and pin encodings for the host controller
// Function
// [R01] Device drops write beats with mask high
// [R02] Write mask sampled on both strobe edges
// [R03] Command pins captured at clock rising edge
// [R04] Device output strobes toggle continuously
// [R05] Wide part: strobe pairs cover halves
// [R06] Mid part: strobe pairs cover halves
// [R07] Narrow part: first strobe pair only
// [R08] Read valid marks valid read data
// [R09] Clock starts only after supplies stable
// [R10] Only no-ops presented at initialization start
// [R11] No-ops for 200 us before mode set
// [R12] Two dummy plus one valid mode set
// [R13] Device resets logic on mode-set burst
// [R14] Burst mode sets ignore recovery time
// [R15] Dummy mode sets drive address low
// [R16] Refresh all eight banks among 1024 no-ops
// [R17] Row cycle time after refresh per bank
// [R18] Chip select high means no new command
// [R19] Write data captured on both strobe edges
package rlh_pkg;
  localparam int         CLK_NS      = 4;
  localparam int         CK_PHASES   = 4;
  localparam int         CK_NS       = CLK_NS * CK_PHASES;
  localparam int         IDLE_NS     = 200000;
  localparam int         IDLE_SLOTS  = (IDLE_NS + CK_NS - 1) / CK_NS;
  localparam int         MRS_DUMMY   = 2;
  localparam int         MRS_TOTAL   = MRS_DUMMY + 1;
  localparam int         RECOV_SLOTS = 6;
  localparam int         TRC_SLOTS   = 8;
  localparam int         INIT_NOPS   = 1024;
  localparam int         NUM_BANKS   = 8;
  localparam int         NOP_GAP     = INIT_NOPS / NUM_BANKS;
  localparam int         WL_SLOTS    = 4;
  localparam logic [1:0] PH_RISE     = 2'h0;
  localparam logic [1:0] PH_FALL     = 2'h2;
  // Pin order {cs_n, we_n, ref_n}
  localparam logic [2:0] PIN_NOP     = 3'h7;
  localparam logic [2:0] PIN_MRS     = 3'h0;
  localparam logic [2:0] PIN_REF     = 3'h2;
  localparam logic [2:0] PIN_WR      = 3'h1;
  localparam logic [2:0] PIN_RD      = 3'h3;

  typedef enum logic [2:0] {CMD_NOP, CMD_MRS, CMD_REF, CMD_WR, CMD_RD} rlh_cmd_t;

  function automatic logic [2:0] rlh_pins(input rlh_cmd_t c);
    case (c)
      CMD_MRS: return PIN_MRS;
      CMD_REF: return PIN_REF;
      CMD_WR:  return PIN_WR;
      CMD_RD:  return PIN_RD;
      default: return PIN_NOP;
    endcase
  endfunction
endpackage

// >>> rlh_init_if.sv
// Interface between the init sequencer and the host core
`timescale 1ns/1ps
`default_nettype none
interface rlh_init_if;
  import rlh_pkg::*;
  logic       slot;
  logic       pwr_ok;
  logic       run;
  logic       done;
  logic       mode_valid;
  logic [2:0] bank;
  rlh_cmd_t   cmd;
  modport seq  (input slot, pwr_ok, output run, done, mode_valid, bank, cmd);
  modport core (output slot, pwr_ok, input run, done, mode_valid, bank, cmd);
endinterface
`default_nettype wire

// >>> rlh_init_seq.sv
// Power-up initialization sequencer
`timescale 1ns/1ps
`default_nettype none
module rlh_init_seq
  import rlh_pkg::*;
#(
  parameter int IDLE_N = IDLE_SLOTS
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic clk_en,
  rlh_init_if.seq   ifc
);
  localparam int CW = $clog2(IDLE_N + NOP_GAP + RECOV_SLOTS + 1);

  typedef enum {S_OFF, S_IDLE, S_MRS, S_RECOV, S_REF, S_DONE} rlh_state_t;
  rlh_state_t    state_reg;
  logic [CW-1:0] cnt_reg;
  logic [3:0]    bank_reg;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= S_OFF;
      cnt_reg   <= '0;
      bank_reg  <= 4'h0;
    end else if (clk_en) begin
      case (state_reg)
        S_OFF: begin
          if (ifc.pwr_ok) state_reg <= S_IDLE; // R09
        end
        S_IDLE: begin
          if (ifc.slot) begin
            if (cnt_reg == CW'(IDLE_N - 1)) begin // R11
              state_reg <= S_MRS;
              cnt_reg   <= '0;
            end else begin
              cnt_reg <= cnt_reg + 1'b1;
            end
          end
        end
        S_MRS: begin
          if (ifc.slot) begin
            if (cnt_reg == CW'(MRS_TOTAL - 1)) begin // R12
              state_reg <= S_RECOV;
              cnt_reg   <= '0;
            end else begin
              cnt_reg <= cnt_reg + 1'b1; // R14
            end
          end
        end
        S_RECOV: begin
          if (ifc.slot) begin
            if (cnt_reg == CW'(RECOV_SLOTS - 1)) begin // R16
              state_reg <= S_REF;
              cnt_reg   <= '0;
            end else begin
              cnt_reg <= cnt_reg + 1'b1;
            end
          end
        end
        S_REF: begin
          if (ifc.slot) begin
            if (cnt_reg == '0) begin // R16
              cnt_reg  <= CW'(NOP_GAP);
              bank_reg <= bank_reg + 4'h1;
            end else if (cnt_reg == CW'(1) && bank_reg == 4'(NUM_BANKS)) begin
              state_reg <= S_DONE;
            end else begin
              cnt_reg <= cnt_reg - 1'b1; // R17
            end
          end
        end
        default: begin
          state_reg <= S_DONE;
        end
      endcase
    end
  end

  // Command for the current slot
  always_comb begin
    ifc.cmd = CMD_NOP; // R10
    if (state_reg == S_MRS) begin
      ifc.cmd = CMD_MRS; // R12
    end else if (state_reg == S_REF && cnt_reg == '0) begin
      ifc.cmd = CMD_REF; // R16
    end
  end

  assign ifc.bank       = bank_reg[2:0];
  assign ifc.mode_valid = (state_reg == S_MRS) && (cnt_reg == CW'(MRS_DUMMY));
  assign ifc.run        = (state_reg != S_OFF);
  assign ifc.done       = (state_reg == S_DONE);

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst || !clk_en);

  property p_clk_after_pwr;
    $rose(ifc.run) |-> $past(ifc.pwr_ok);
  endproperty
  a_clk_after_pwr: assert property (p_clk_after_pwr) // R09
    else $error("device clock started before supplies stable");

  property p_nop_only;
    (state_reg inside {S_OFF, S_IDLE, S_RECOV}) |-> ifc.cmd == CMD_NOP;
  endproperty
  a_nop_only: assert property (p_nop_only) // R10
    else $error("non-nop command during idle phase");

  property p_idle_len;
    (state_reg == S_IDLE ##1 state_reg == S_MRS)
      |-> $past(cnt_reg) == CW'(IDLE_N - 1);
  endproperty
  a_idle_len: assert property (p_idle_len) // R11
    else $error("idle period before mode set too short");

  property p_mrs_count;
    $rose(state_reg == S_RECOV)
      |-> $past(state_reg) == S_MRS && $past(cnt_reg) == CW'(MRS_TOTAL - 1);
  endproperty
  a_mrs_count: assert property (p_mrs_count) // R12
    else $error("wrong number of mode sets in burst");

  property p_mrs_b2b;
    (ifc.slot && state_reg == S_MRS && cnt_reg == '0)
      |-> ##4 (ifc.slot && ifc.cmd == CMD_MRS)
          ##4 (ifc.slot && ifc.cmd == CMD_MRS);
  endproperty
  a_mrs_b2b: assert property (p_mrs_b2b) // R14
    else $error("mode sets not back to back");

  property p_recov;
    $rose(state_reg == S_REF) |-> $past(cnt_reg) == CW'(RECOV_SLOTS - 1);
  endproperty
  a_recov: assert property (p_recov) // R16
    else $error("refresh before mode-set recovery");

  property p_all_banks;
    $rose(state_reg == S_DONE) |-> $past(bank_reg) == 4'(NUM_BANKS);
  endproperty
  a_all_banks: assert property (p_all_banks) // R16
    else $error("init finished without refreshing all banks");
endmodule
`default_nettype wire

// >>> rlh_dev_model.sv
// Behavioural model of the memory device facing the host controller
`timescale 1ns/1ps
`default_nettype none
module rlh_dev_model
  import rlh_pkg::*;
#(
  parameter int  DW      = 36,
  parameter int  AW      = 21,
  parameter real HALF_NS = 62.5
) (
  input  wire logic          ck_p,
  input  wire logic          cs_n,
  input  wire logic          we_n,
  input  wire logic          ref_n,
  input  wire logic [AW-1:0] addr_o,
  input  wire logic [2:0]    bank_o,
  input  wire logic [1:0]    in_data_strobe_p,
  input  wire logic          wmask_o,
  input  wire logic [DW-1:0] dq_o,
  input  wire logic          dq_oe,
  output logic [DW-1:0]      dq_i,
  output logic [1:0]         out_data_strobe_i,
  output logic               read_valid_i
);
  logic [DW-1:0]   mem [logic [AW+3:0]];
  logic [AW+2:0]   wq [$];
  logic [AW+2:0]   rq [$];
  logic [AW+2:0]   wkey;
  logic [AW+2:0]   rkey;
  logic [DW/2-1:0] lo_half;
  int              mrs_run = 0;
  bit              rd_second = 0;

  // Command decode at the device clock rise
  always @(posedge ck_p) begin
    if (!cs_n) begin
      if ({we_n, ref_n} == 2'b00) begin
        mrs_run = mrs_run + 1;
        if (mrs_run == MRS_TOTAL) begin
          wq.delete();
          rq.delete();
        end
      end else begin
        mrs_run = 0;
        if ({we_n, ref_n} == 2'b01) wq.push_back({bank_o, addr_o});
        if ({we_n, ref_n} == 2'b11) rq.push_back({bank_o, addr_o});
      end
    end else mrs_run = 0;
  end

  // Write beats on both strobe edges, lower half on the first pair
  always @(in_data_strobe_p[0]) begin
    if (dq_oe) lo_half = dq_o[DW/2-1:0];
  end
  always @(in_data_strobe_p[1]) begin
    #0.1;
    if (dq_oe) begin
      if (in_data_strobe_p[1] && wq.size() > 0) wkey = wq.pop_front();
      if (!wmask_o) begin
        mem[{wkey, ~in_data_strobe_p[1]}] = {dq_o[DW-1:DW/2], lo_half};
      end
    end
  end

  // Free-running output strobes, data and valid change on their edges
  initial begin
    out_data_strobe_i = 2'h0;
    read_valid_i = 1'b0;
    dq_i = '0;
    #37.3;
    forever begin
      #(HALF_NS);
      out_data_strobe_i = ~out_data_strobe_i;
      if (rd_second) begin
        dq_i = mem.exists({rkey, 1'b1}) ? mem[{rkey, 1'b1}] : ~dq_i;
        rd_second = 0;
      end else if (rq.size() > 0) begin
        rkey = rq.pop_front();
        dq_i = mem.exists({rkey, 1'b0}) ? mem[{rkey, 1'b0}] : ~dq_i;
        read_valid_i = 1'b1;
        rd_second = 1;
      end else begin
        read_valid_i = 1'b0;
        dq_i = ~dq_i;
      end
    end
  end
endmodule
`default_nettype wire

// >>> rlh_host_ctrl_tb_top.sv
// Self-checking bench for the host controller with a device model
`timescale 1ns/1ps
`default_nettype none
module rlh_host_ctrl_tb_top;
  import rlh_pkg::*;
  localparam int DW     = 36;
  localparam int AW     = 21;
  localparam int IDLE_T = 20;
  localparam int LIMIT  = 30000;
  logic            clk, sys_rst, clk_en, pwr_ok, usr_req, usr_we;
  logic            usr_ready, init_done, rd_valid, ck_p, ck_n;
  logic            cs_n, we_n, ref_n, wmask_o, dq_oe, read_valid_i;
  logic [AW-1:0]   mode_cfg, usr_addr, addr_o;
  logic [2:0]      usr_bank, bank_o, cmdv;
  logic [2*DW-1:0] usr_wdata;
  logic [1:0]      usr_wmask, m;
  logic [1:0]      in_data_strobe_p, in_data_strobe_n, out_data_strobe_i;
  logic [DW-1:0]   rd_data, dq_o, dq_i;
  logic [95:0]     r0, r1, r2;
  logic [7:0]      banks_done = 8'h00;
  logic [DW-1:0]   expq [$];
  int              last_use [8];
  int              mismatches = 0;
  int              checks_done = 0;
  int              seed, i, n;
  int              cyc = 0;
  int              slot = 0;
  int              nops = 0;
  int              mrs_n = 0;
  int              refs_seen = 0;

  rlh_host_ctrl #(.DW(DW), .AW(AW), .IDLE_N(IDLE_T)) dut_u (
    .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .pwr_ok(pwr_ok),
    .mode_cfg(mode_cfg), .usr_req(usr_req), .usr_we(usr_we),
    .usr_bank(usr_bank), .usr_addr(usr_addr), .usr_wdata(usr_wdata),
    .usr_wmask(usr_wmask), .usr_ready(usr_ready), .init_done(init_done),
    .rd_data(rd_data), .rd_valid(rd_valid), .ck_p(ck_p), .ck_n(ck_n),
    .cs_n(cs_n), .we_n(we_n), .ref_n(ref_n), .addr_o(addr_o),
    .bank_o(bank_o), .in_data_strobe_p(in_data_strobe_p),
    .in_data_strobe_n(in_data_strobe_n), .wmask_o(wmask_o),
    .dq_o(dq_o), .dq_oe(dq_oe), .dq_i(dq_i),
    .out_data_strobe_i(out_data_strobe_i), .read_valid_i(read_valid_i));

  rlh_dev_model #(.DW(DW), .AW(AW)) dev_u (
    .ck_p(ck_p), .cs_n(cs_n), .we_n(we_n), .ref_n(ref_n),
    .addr_o(addr_o), .bank_o(bank_o), .in_data_strobe_p(in_data_strobe_p),
    .wmask_o(wmask_o), .dq_o(dq_o), .dq_oe(dq_oe), .dq_i(dq_i),
    .out_data_strobe_i(out_data_strobe_i), .read_valid_i(read_valid_i));

  task automatic chk(input logic [2*DW-1:0] got, input logic [2*DW-1:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t got %0h exp %0h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    if (mismatches == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // One user request, held until the edge that takes it
  task automatic usr_op(input logic we, input logic [2*DW-1:0] d,
                        input logic [1:0] mk);
    int k;
    k = 0;
    while (usr_ready !== 1'b1 && k < 2000) begin
      @(negedge clk);
      k++;
    end
    usr_req = 1'b1;
    usr_we = we;
    usr_bank = r2[AW+2:AW];
    usr_addr = r2[AW-1:0];
    usr_wdata = d;
    usr_wmask = mk;
    @(negedge clk);
    usr_req = 1'b0;
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      mismatches++;
      tally_and_finish();
    end
  end

  // Read beats compared against the oldest expectation
  always @(negedge clk) begin
    if (sys_rst === 1'b0) begin
      chk({ck_n, in_data_strobe_n}, {~ck_p, ~in_data_strobe_p});
    end
    if (rd_valid === 1'b1) begin
      if (expq.size() == 0) chk(1'b1, 1'b0);
      else chk(rd_data, expq.pop_front());
    end
  end

  // Command slot monitor at the device clock rise
  always @(posedge ck_p) begin
    cmdv = {cs_n, we_n, ref_n};
    slot++;
    if (mrs_n == 0 && cmdv !== PIN_MRS) begin
      chk(cmdv, PIN_NOP);
      nops++;
    end else if (cmdv === PIN_MRS) begin
      if (mrs_n == 0) chk(nops >= IDLE_T, 1'b1);
      mrs_n++;
      chk(addr_o, (mrs_n == MRS_TOTAL) ? mode_cfg : '0);
      nops = 0;
    end else if (cmdv === PIN_NOP) begin
      if (nops == 0) chk(mrs_n, MRS_TOTAL);
      nops++;
    end else begin
      if (refs_seen == 0) chk(nops >= RECOV_SLOTS, 1'b1);
      if (init_done !== 1'b1) chk(cmdv, PIN_REF);
      if (cmdv === PIN_REF) banks_done[bank_o] = 1'b1;
      refs_seen++;
      if (last_use[bank_o] >= 0) chk(slot - last_use[bank_o] >= TRC_SLOTS, 1'b1);
      last_use[bank_o] = slot;
    end
  end

  initial begin
    seed = 32'h0e34;
    foreach (last_use[k]) last_use[k] = -1;
    sys_rst = 1'b1;
    clk_en = 1'b1;
    pwr_ok = 1'b0;
    usr_req = 1'b0;
    usr_we = 1'b0;
    usr_bank = 3'h0;
    usr_addr = '0;
    usr_wdata = '0;
    usr_wmask = 2'h0;
    r2 = {$random(seed), $random(seed), $random(seed)};
    mode_cfg = r2[AW-1:0];
    repeat (3) @(negedge clk);
    sys_rst = 1'b0;
    repeat (40) begin
      @(negedge clk);
      chk(ck_p, 1'b0);
    end
    pwr_ok = 1'b1;
    wait (init_done === 1'b1);
    @(negedge clk);
    chk({banks_done, nops >= INIT_NOPS}, {8'hff, 1'b1});
    clk_en = 1'b0;
    r0[2:0] = {ck_p, in_data_strobe_p[0], usr_ready};
    repeat (6) begin
      @(negedge clk);
      chk({ck_p, in_data_strobe_p[0], usr_ready}, r0[2:0]);
    end
    clk_en = 1'b1;
    for (i = 0; i < 12; i++) begin
      r0 = {$random(seed), $random(seed), $random(seed)};
      r1 = {$random(seed), $random(seed), $random(seed)};
      r2 = {$random(seed), $random(seed), $random(seed)};
      m = (i < 4) ? i[1:0] : r1[95:94];
      usr_op(1'b1, r0[2*DW-1:0], 2'h0);
      usr_op(1'b1, r1[2*DW-1:0], m);
      expq.push_back(m[0] ? r0[DW-1:0] : r1[DW-1:0]);
      expq.push_back(m[1] ? r0[2*DW-1:DW] : r1[2*DW-1:DW]);
      usr_op(1'b0, '0, 2'h0);
    end
    n = 0;
    while (expq.size() > 0 && n < 5000) begin
      @(negedge clk);
      n++;
    end
    chk(expq.size(), 0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
